// >>> src/tcc_cap_chan.sv
// One input capture channel with edge select, read lock and two-step flag clear.
module tcc_cap_chan (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Synchronised pin and controls.
  input  wire logic        pin_sync,
  input  wire logic        edge_rise,
  input  wire logic        allow,
  input  wire logic [15:0] count,
  // Register access events.
  input  wire logic        hi_read,
  input  wire logic        lo_access,
  input  wire logic        status_read,
  // State out.
  output logic [15:0]      value_r,
  output logic             flag_r
);

  logic        pin_d_r;
  logic        pin_d_nxt;
  logic        lock_r;
  logic        lock_nxt;
  logic        armed_r;
  logic        armed_nxt;
  logic [15:0] value_nxt;
  logic        flag_nxt;
  logic        hit;

  // Edge detection, capture, locking and the two-step flag clear.
  always_comb begin
    pin_d_nxt = pin_sync;
    hit       = allow && !lock_r && (edge_rise ? (pin_sync && !pin_d_r)
                                               : (!pin_sync && pin_d_r));
    lock_nxt  = lock_r;
    if (hi_read) begin
      lock_nxt = 1'b1;
    end else if (lo_access) begin
      lock_nxt = 1'b0;
    end
    value_nxt = hit ? count : value_r;
    armed_nxt = armed_r;
    if (status_read && flag_r) begin
      armed_nxt = 1'b1;
    end
    flag_nxt = flag_r;
    if (lo_access && armed_r) begin
      flag_nxt  = 1'b0;
      armed_nxt = 1'b0;
    end
    if (hit) begin
      flag_nxt = 1'b1; // Set wins over clear.
    end
  end

  // State registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_d_r <= 1'b0;
      lock_r  <= 1'b0;
      armed_r <= 1'b0;
      value_r <= 16'h0000;
      flag_r  <= 1'b0;
    end else begin
      pin_d_r <= pin_d_nxt;
      lock_r  <= lock_nxt;
      armed_r <= armed_nxt;
      value_r <= value_nxt;
      flag_r  <= flag_nxt;
    end
  end

endmodule // tcc_cap_chan

// >>> src/tcc_pkg.sv
// Package of register offsets, field positions, reset values and shared types for the timer.
package tcc_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [4:0] ADDR_CTRL_ONE   = 5'h00;
  localparam logic [4:0] ADDR_CTRL_TWO   = 5'h01;
  localparam logic [4:0] ADDR_STATUS     = 5'h02;
  localparam logic [4:0] ADDR_CAP1_HI    = 5'h03;
  localparam logic [4:0] ADDR_CAP1_LO    = 5'h04;
  localparam logic [4:0] ADDR_CMP1_HI    = 5'h05;
  localparam logic [4:0] ADDR_CMP1_LO    = 5'h06;
  localparam logic [4:0] ADDR_CNT_HI     = 5'h07;
  localparam logic [4:0] ADDR_CNT_LO     = 5'h08;
  localparam logic [4:0] ADDR_ACNT_HI    = 5'h09;
  localparam logic [4:0] ADDR_ACNT_LO    = 5'h0a;
  localparam logic [4:0] ADDR_CAP2_HI    = 5'h0b;
  localparam logic [4:0] ADDR_CAP2_LO    = 5'h0c;
  localparam logic [4:0] ADDR_CMP2_HI    = 5'h0d;
  localparam logic [4:0] ADDR_CMP2_LO    = 5'h0e;

  // Control one fields.
  localparam int C1_CAP_IRQ_EN  = 7;
  localparam int C1_CMP_IRQ_EN  = 6;
  localparam int C1_OVF_IRQ_EN  = 5;
  localparam int C1_CAP_EDGE1   = 1;
  localparam int C1_CMP_LVL1    = 0;
  localparam int C1_CMP_LVL2    = 2;
  localparam int C1_CAP_EDGE2   = 3;

  // Control two fields.
  localparam int C2_CMP_OE1     = 7;
  localparam int C2_CMP_OE2     = 6;
  localparam int C2_ONE_PULSE   = 5;
  localparam int C2_PWM         = 4;
  localparam int C2_CLK_SEL_HI  = 3;
  localparam int C2_CLK_SEL_LO  = 2;
  localparam int C2_EXT_EDGE    = 0;

  // Status fields.
  localparam int ST_CAP_FLAG1   = 7;
  localparam int ST_CMP_FLAG1   = 6;
  localparam int ST_OVF_FLAG    = 5;
  localparam int ST_CAP_FLAG2   = 4;
  localparam int ST_CMP_FLAG2   = 3;

  // Reset values and the counter maximum.
  localparam logic [15:0] COUNT_RELOAD   = 16'hfffc;
  localparam logic [15:0] COUNT_MAX      = 16'hffff;
  localparam logic [15:0] COMPARE_RESET  = 16'h8000;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;

  // Clock select codes.
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV4 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;

  // Register port request.
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcc_bus_req_t;

endpackage

// >>> src/tcc_timer.sv
// Top of the 16-bit timer with two captures, two compares and external clock.
//
// The register addresses and the strobed register port were chosen for this implementation.
module tcc_timer (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Register port.
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata_r,
  // System state.
  input  wire logic       irq_mask,
  input  wire logic       halt_mode,
  // Pins.
  input  wire logic       ext_clock_pin,
  input  wire logic [1:0] capture_pin,
  output logic [1:0]      compare_pin_r,
  output logic [1:0]      compare_pin_oe_r,
  // Interrupt request.
  output logic            timer_irq_r
);

  tcc_pkg::tcc_bus_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic       ext_d_r;
  // Bit 2 carries the external clock pin, bits 1:0 the capture pins.

  // Two flops on every pin input before any logic looks at it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      ext_d_r  <= 1'b0;
    end else begin
      pin_s1_r <= {ext_clock_pin, capture_pin};
      pin_s2_r <= pin_s1_r;
      ext_d_r  <= pin_s2_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and decode.

  logic [7:0]  ctrl1_r;
  logic [7:0]  ctrl1_nxt;
  logic [7:0]  ctrl2_r;
  logic [7:0]  ctrl2_nxt;
  logic [15:0] cmp_r     [2];
  logic [15:0] cmp_nxt   [2];
  logic [1:0]  cmp_hold_r;
  logic [1:0]  cmp_hold_nxt;
  logic [1:0]  cmp_flag_r;
  logic [1:0]  cmp_flag_nxt;
  logic [1:0]  cmp_arm_r;
  logic [1:0]  cmp_arm_nxt;
  logic [1:0]  cap_flag;
  logic [15:0] cap_val   [2];
  logic        st_rd;
  logic        cnt_lo_acc;
  logic        acnt_lo_acc;
  logic        cnt_hi_rd;
  logic [1:0]  cap_hi_rd;
  logic [1:0]  cap_lo_acc;
  logic [1:0]  cmp_hi_wr;
  logic [1:0]  cmp_lo_acc;
  logic [1:0]  cmp_lo_wr;
  logic        pulse_mode;

  assign st_rd       = req.rd && req.addr == tcc_pkg::ADDR_STATUS;
  assign cnt_lo_acc  = (req.rd || req.wr) && req.addr == tcc_pkg::ADDR_CNT_LO;
  assign acnt_lo_acc = (req.rd || req.wr) && req.addr == tcc_pkg::ADDR_ACNT_LO;
  assign cnt_hi_rd   = req.rd && (req.addr == tcc_pkg::ADDR_CNT_HI
                                  || req.addr == tcc_pkg::ADDR_ACNT_HI);
  assign cap_hi_rd   = {req.rd && req.addr == tcc_pkg::ADDR_CAP2_HI,
                        req.rd && req.addr == tcc_pkg::ADDR_CAP1_HI};
  assign cap_lo_acc  = {(req.rd || req.wr) && req.addr == tcc_pkg::ADDR_CAP2_LO,
                        (req.rd || req.wr) && req.addr == tcc_pkg::ADDR_CAP1_LO};
  assign cmp_hi_wr   = {req.wr && req.addr == tcc_pkg::ADDR_CMP2_HI,
                        req.wr && req.addr == tcc_pkg::ADDR_CMP1_HI};
  assign cmp_lo_wr   = {req.wr && req.addr == tcc_pkg::ADDR_CMP2_LO,
                        req.wr && req.addr == tcc_pkg::ADDR_CMP1_LO};
  assign cmp_lo_acc  = cmp_lo_wr | {req.rd && req.addr == tcc_pkg::ADDR_CMP2_LO,
                                    req.rd && req.addr == tcc_pkg::ADDR_CMP1_LO};
  assign pulse_mode  = ctrl2_r[tcc_pkg::C2_ONE_PULSE] || ctrl2_r[tcc_pkg::C2_PWM];

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and counter.

  logic [2:0]  div_r;
  logic [2:0]  div_nxt;
  logic        tick;
  logic        ext_edge;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic        ovf_flag_r;
  logic        ovf_flag_nxt;
  logic        ovf_arm_r;
  logic        ovf_arm_nxt;
  logic [7:0]  lo_buf_r;
  logic [7:0]  lo_buf_nxt;
  logic        lo_held_r;
  logic        lo_held_nxt;
  logic        wrap;

  // Active edge of the synchronised clock pin, chosen by the edge select bit.
  assign ext_edge = ctrl2_r[tcc_pkg::C2_EXT_EDGE] ? (pin_s2_r[2] && !ext_d_r)
                                                  : (!pin_s2_r[2] && ext_d_r);

  // Timer tick from the divider or the external edge; halt freezes both.
  always_comb begin
    div_nxt = halt_mode ? div_r : div_r + 3'h1;
    case (ctrl2_r[tcc_pkg::C2_CLK_SEL_HI:tcc_pkg::C2_CLK_SEL_LO])
      tcc_pkg::CLK_DIV2: tick = div_r[0];
      tcc_pkg::CLK_DIV4: tick = div_r[1:0] == 2'h3;
      tcc_pkg::CLK_DIV8: tick = div_r == 3'h7;
      tcc_pkg::CLK_EXT:  tick = ext_edge;
      default:           tick = 1'b0;
    endcase
    tick = tick && !halt_mode;
  end

  // Counter, overflow flag and the high-first read buffer.
  always_comb begin
    wrap      = tick && count_r == tcc_pkg::COUNT_MAX;
    count_nxt = tick ? count_r + 16'h0001 : count_r;
    if (req.wr && (cnt_lo_acc || acnt_lo_acc)) begin
      count_nxt = tcc_pkg::COUNT_RELOAD;
    end
    lo_buf_nxt  = lo_buf_r;
    lo_held_nxt = lo_held_r;
    if (cnt_hi_rd) begin
      lo_held_nxt = 1'b1;
      if (!lo_held_r) begin
        lo_buf_nxt = count_r[7:0];
      end
    end else if (req.rd && (cnt_lo_acc || acnt_lo_acc)) begin
      // A low-byte read of either view ends the buffered sequence.
      lo_held_nxt = 1'b0;
    end
    ovf_arm_nxt  = ovf_arm_r || (st_rd && ovf_flag_r);
    ovf_flag_nxt = ovf_flag_r;
    if (cnt_lo_acc && ovf_arm_r) begin
      ovf_flag_nxt = 1'b0;
      ovf_arm_nxt  = 1'b0;
    end
    if (wrap) begin
      ovf_flag_nxt = 1'b1;
    end
  end

  // Counter state registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r      <= 3'h0;
      count_r    <= tcc_pkg::COUNT_RELOAD;
      ovf_flag_r <= 1'b0;
      ovf_arm_r  <= 1'b0;
      lo_buf_r   <= 8'h00;
      lo_held_r  <= 1'b0;
    end else begin
      div_r      <= div_nxt;
      count_r    <= count_nxt;
      ovf_flag_r <= ovf_flag_nxt;
      ovf_arm_r  <= ovf_arm_nxt;
      lo_buf_r   <= lo_buf_nxt;
      lo_held_r  <= lo_held_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture channels.

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cap
      tcc_cap_chan u_cap (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .pin_sync    (pin_s2_r[gi]),
        .edge_rise   (gi == 0 ? ctrl1_r[tcc_pkg::C1_CAP_EDGE1]
                              : ctrl1_r[tcc_pkg::C1_CAP_EDGE2]),
        .allow       (gi == 1 || !pulse_mode),
        .count       (count_r),
        .hi_read     (cap_hi_rd[gi]),
        .lo_access   (cap_lo_acc[gi]),
        .status_read (st_rd),
        .value_r     (cap_val[gi]),
        .flag_r      (cap_flag[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Control and compare registers.

  logic [1:0] match;
  logic [1:0] pin_nxt;
  logic [1:0] oe_nxt;
  logic [1:0] lvl;

  assign lvl = {ctrl1_r[tcc_pkg::C1_CMP_LVL2], ctrl1_r[tcc_pkg::C1_CMP_LVL1]};

  // Software writes, compare matching and compare flag handling.
  always_comb begin
    ctrl1_nxt = (req.wr && req.addr == tcc_pkg::ADDR_CTRL_ONE) ? req.wdata : ctrl1_r;
    ctrl2_nxt = (req.wr && req.addr == tcc_pkg::ADDR_CTRL_TWO) ? req.wdata : ctrl2_r;
    cmp_hold_nxt = cmp_hold_r;
    cmp_flag_nxt = cmp_flag_r;
    cmp_arm_nxt  = cmp_arm_r | ({2{st_rd}} & cmp_flag_r);
    pin_nxt      = compare_pin_r;
    // Enables track the control register with no extra cycle of lag.
    oe_nxt       = {ctrl2_nxt[tcc_pkg::C2_CMP_OE2], ctrl2_nxt[tcc_pkg::C2_CMP_OE1]};
    for (int i = 0; i < 2; i++) begin
      cmp_nxt[i] = cmp_r[i];
      if (cmp_hi_wr[i]) begin
        cmp_nxt[i][15:8] = req.wdata;
        cmp_hold_nxt[i]  = 1'b1;
      end
      if (cmp_lo_wr[i]) begin
        cmp_nxt[i][7:0] = req.wdata;
        cmp_hold_nxt[i] = 1'b0;
        cmp_flag_nxt[i] = 1'b0;
        cmp_arm_nxt[i]  = 1'b0;
      end else if (cmp_lo_acc[i] && cmp_arm_r[i]) begin
        cmp_flag_nxt[i] = 1'b0;
        cmp_arm_nxt[i]  = 1'b0;
      end
      match[i] = tick && !cmp_hold_r[i] && count_r == cmp_r[i];
      if (match[i]) begin
        cmp_flag_nxt[i] = 1'b1;
        if (compare_pin_oe_r[i]) begin
          pin_nxt[i] = lvl[i];
        end
      end
    end
  end

  // Control and compare state registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_r          <= tcc_pkg::CTRL_RESET;
      ctrl2_r          <= tcc_pkg::CTRL_RESET;
      cmp_r[0]         <= tcc_pkg::COMPARE_RESET;
      cmp_r[1]         <= tcc_pkg::COMPARE_RESET;
      cmp_hold_r       <= 2'h0;
      cmp_flag_r       <= 2'h0;
      cmp_arm_r        <= 2'h0;
      compare_pin_r    <= 2'h0;
      compare_pin_oe_r <= 2'h0;
    end else begin
      ctrl1_r          <= ctrl1_nxt;
      ctrl2_r          <= ctrl2_nxt;
      cmp_r[0]         <= cmp_nxt[0];
      cmp_r[1]         <= cmp_nxt[1];
      cmp_hold_r       <= cmp_hold_nxt;
      cmp_flag_r       <= cmp_flag_nxt;
      cmp_arm_r        <= cmp_arm_nxt;
      compare_pin_r    <= pin_nxt;
      compare_pin_oe_r <= oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and interrupt request.

  logic [7:0] rdata_nxt;
  logic [7:0] status;
  logic       irq_nxt;

  assign status = {cap_flag[0], cmp_flag_r[0], ovf_flag_r, cap_flag[1], cmp_flag_r[1], 3'h0};

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    case (req.addr)
      tcc_pkg::ADDR_CTRL_ONE: rdata_nxt = ctrl1_r;
      tcc_pkg::ADDR_CTRL_TWO: rdata_nxt = ctrl2_r;
      tcc_pkg::ADDR_STATUS:   rdata_nxt = status;
      tcc_pkg::ADDR_CAP1_HI:  rdata_nxt = cap_val[0][15:8];
      tcc_pkg::ADDR_CAP1_LO:  rdata_nxt = cap_val[0][7:0];
      tcc_pkg::ADDR_CAP2_HI:  rdata_nxt = cap_val[1][15:8];
      tcc_pkg::ADDR_CAP2_LO:  rdata_nxt = cap_val[1][7:0];
      tcc_pkg::ADDR_CMP1_HI:  rdata_nxt = cmp_r[0][15:8];
      tcc_pkg::ADDR_CMP1_LO:  rdata_nxt = cmp_r[0][7:0];
      tcc_pkg::ADDR_CMP2_HI:  rdata_nxt = cmp_r[1][15:8];
      tcc_pkg::ADDR_CMP2_LO:  rdata_nxt = cmp_r[1][7:0];
      tcc_pkg::ADDR_CNT_HI,
      tcc_pkg::ADDR_ACNT_HI:  rdata_nxt = count_r[15:8];
      tcc_pkg::ADDR_CNT_LO,
      tcc_pkg::ADDR_ACNT_LO:  rdata_nxt = lo_held_r ? lo_buf_r : count_r[7:0];
      default:                rdata_nxt = 8'h00;
    endcase
    if (!req.rd) begin
      rdata_nxt = 8'h00;
    end
    irq_nxt = !irq_mask && ((ctrl1_r[tcc_pkg::C1_OVF_IRQ_EN] && ovf_flag_r)
                         || (ctrl1_r[tcc_pkg::C1_CAP_IRQ_EN] && |cap_flag)
                         || (ctrl1_r[tcc_pkg::C1_CMP_IRQ_EN] && |cmp_flag_r));
  end

  // Output registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
      timer_irq_r <= 1'b0;
    end else begin
      reg_rdata_r <= rdata_nxt;
      timer_irq_r <= irq_nxt;
    end
  end

endmodule // tcc_timer

// >>> tb/tcc_ext_clk_model.sv
// Model of the external clock source that drives the timer's clock pin.
module tcc_ext_clk_model (
  // Clock.
  input  wire logic sys_clk,
  // Control from the bench.
  input  wire logic run,
  // Pin to the timer.
  output logic      ext_clock_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cnt = 0;

  // Toggle every four CPU clocks so active edges stay eight clocks apart; idle low.
  always @(negedge sys_clk) begin
    if (!run) begin
      cnt = 0;
      ext_clock_pin = 1'b0;
    end else if (cnt == 3) begin
      cnt = 0;
      ext_clock_pin = ~ext_clock_pin;
    end else begin
      cnt++;
    end
  end
endmodule // tcc_ext_clk_model

// >>> tb/tcc_timer_chk.sv
// Port-level checker of the timer's register answers, compare pins and interrupt.
module tcc_timer_chk (
  // Clock and reset.
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Register port.
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_r,
  // System state and pins.
  input wire logic       irq_mask,
  input wire logic [1:0] compare_pin_r,
  input wire logic [1:0] compare_pin_oe_r,
  input wire logic       timer_irq_r
);
  timeunit 1ns;
  timeprecision 1ns;

  // All checks share the one clock and its reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
    else $error("read data not zero outside a read answer");
  unmapped_read_a:
    assert property (reg_rd && reg_addr > 5'h0e |=> reg_rdata_r == 8'h00)
    else $error("unmapped read returned data");
  irq_masked_a:
    assert property (irq_mask |=> !timer_irq_r)
    else $error("interrupt raised while masked");
  irq_fall_a:
    assert property ($fell(timer_irq_r) |-> $past(irq_mask) || $past(reg_wr || reg_rd)
                     || $past(reg_wr || reg_rd, 2))
    else $error("interrupt dropped without an access");
  pin_reset_a:
    assert property ($rose(rst_n) |-> compare_pin_r == 2'b00)
    else $error("compare pins not low out of reset");
  oe_write_a:
    assert property (reg_wr && reg_addr == tcc_pkg::ADDR_CTRL_TWO |=>
                     compare_pin_oe_r == {$past(reg_wdata[6]), $past(reg_wdata[7])})
    else $error("output enable does not follow its control write");
  pin_needs_oe_a:
    assert property ($changed(compare_pin_r) |->
      (($past(compare_pin_r) ^ compare_pin_r) & ~($past(compare_pin_oe_r) | compare_pin_oe_r))
      == 2'b00)
    else $error("compare pin moved while its output is disabled");
  ctrl_readback_a:
    assert property (reg_rd && reg_addr == tcc_pkg::ADDR_CTRL_TWO |=>
                     reg_rdata_r[7:6] == {compare_pin_oe_r[0], compare_pin_oe_r[1]})
    else $error("control two read disagrees with output enables");
endmodule // tcc_timer_chk

bind tcc_timer tcc_timer_chk chk (
  .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
  .irq_mask, .compare_pin_r, .compare_pin_oe_r, .timer_irq_r
);

// >>> tb/tcc_timer_test.sv
// Self-checking bench for the 16-bit timer with captures and compares.
module tcc_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk;
  logic        rst_n;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata_r;
  logic        irq_mask;
  logic        halt_mode;
  logic        ext_run;
  logic        ext_clock_pin;
  logic [1:0]  capture_pin;
  logic [1:0]  compare_pin_r;
  logic [1:0]  compare_pin_oe_r;
  logic        timer_irq_r;
  logic [7:0]  d;
  logic [15:0] v;
  logic [15:0] w;
  logic [15:0] n;
  int          mismatches;
  int          check_count;

  // Design and the external clock source.
  tcc_timer dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
    .irq_mask, .halt_mode, .ext_clock_pin, .capture_pin, .compare_pin_r, .compare_pin_oe_r,
    .timer_irq_r);
  tcc_ext_clk_model ext (.sys_clk, .run(ext_run), .ext_clock_pin);

  // Clock of 100 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare helpers and bus cycles.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input logic [15:0] got, input int e);
    chk({15'h0000, (got >= e - 1) && (got <= e + 1)}, 16'h0001);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] x);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= x;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 x = reg_rdata_r;
  endtask
  task automatic rd16(input logic [4:0] a, output logic [15:0] x);
    rd(a, x[15:8]);
    rd(a + 5'h01, x[7:0]);
  endtask
  // Counts advanced over exactly 160 cycles between two high-byte latches.
  task automatic span(output logic [15:0] c);
    rd16(tcc_pkg::ADDR_CNT_HI, v);
    repeat (156) @(posedge sys_clk);
    rd16(tcc_pkg::ADDR_ACNT_HI, w);
    c = w - v;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    chk(compare_pin_r, 16'h0000);
    rd16(tcc_pkg::ADDR_CMP1_HI, v);
    chk(v, tcc_pkg::COMPARE_RESET);
    rd16(tcc_pkg::ADDR_CMP2_HI, v);
    chk(v, tcc_pkg::COMPARE_RESET);
    rd(tcc_pkg::ADDR_CTRL_TWO, d);
    chk(d, tcc_pkg::CTRL_RESET);
    rd(5'h1f, d);
    chk(d, 8'h00);
  endtask
  task automatic t_overflow();
    wr(tcc_pkg::ADDR_CTRL_ONE, 8'h20);
    rd(tcc_pkg::ADDR_STATUS, d);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h00);
    rd(tcc_pkg::ADDR_STATUS, d);
    chk(d[5], 1'b0);
    repeat (10) @(posedge sys_clk);
    rd(tcc_pkg::ADDR_STATUS, d);
    chk(d[5], 1'b1);
    chk(timer_irq_r, 1'b0);
    irq_mask <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(timer_irq_r, 1'b1);
    rd(tcc_pkg::ADDR_STATUS, d);
    rd(tcc_pkg::ADDR_ACNT_LO, d);
    rd(tcc_pkg::ADDR_STATUS, d);
    chk(d[5], 1'b1);
    rd(tcc_pkg::ADDR_CNT_LO, d);
    rd(tcc_pkg::ADDR_STATUS, d);
    chk(d[5], 1'b0);
    chk(timer_irq_r, 1'b0);
    wr(tcc_pkg::ADDR_CTRL_ONE, 8'h00);
  endtask
  task automatic t_readseq();
    rd(tcc_pkg::ADDR_CNT_HI, d);
    repeat (100) @(posedge sys_clk);
    rd(tcc_pkg::ADDR_ACNT_HI, d);
    rd(tcc_pkg::ADDR_CNT_LO, v[7:0]);
    rd(tcc_pkg::ADDR_ACNT_LO, w[7:0]);
    d = w[7:0] - v[7:0];
    chk_near({8'h00, d}, 53);
  endtask
  task automatic t_clock();
    @(posedge sys_clk);
    halt_mode <= 1'b1;
    span(n);
    chk(n, 16'h0000);
    halt_mode <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      wr(tcc_pkg::ADDR_CTRL_TWO, {4'h0, k[1:0], 2'b00});
      span(n);
      chk_near(n, 160 >> (k + 1));
    end
    ext_run <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      wr(tcc_pkg::ADDR_CTRL_TWO, {4'h0, tcc_pkg::CLK_EXT, 1'b0, e[0]});
      span(n);
      chk_near(n, 20);
    end
    wr(tcc_pkg::ADDR_CTRL_TWO, 8'h00);
    ext_run <= 1'b0;
  endtask
  task automatic t_capture();
    wr(tcc_pkg::ADDR_CTRL_ONE, 8'h8a);
    halt_mode <= 1'b1;
    rd16(tcc_pkg::ADDR_CNT_HI, v);
    capture_pin <= 2'b01;
    repeat (6) @(posedge sys_clk);
    rd(tcc_pkg::ADDR_STATUS, d);
    chk(d[7], 1'b1);
    chk(timer_irq_r, 1'b1);
    rd16(tcc_pkg::ADDR_CAP1_HI, w);
    chk(w, v);
    rd(tcc_pkg::ADDR_STATUS, d);
    chk(d[7], 1'b0);
    rd(tcc_pkg::ADDR_CAP1_HI, d);
    capture_pin <= 2'b00;
    halt_mode   <= 1'b0;
    repeat (10) @(posedge sys_clk);
    capture_pin <= 2'b01;
    halt_mode   <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(tcc_pkg::ADDR_STATUS, d);
    chk(d[7], 1'b0);
    rd(tcc_pkg::ADDR_CAP1_LO, d);
    capture_pin <= 2'b00;
    repeat (6) @(posedge sys_clk);
    rd(tcc_pkg::ADDR_STATUS, d);
    chk(d[7], 1'b0);
    capture_pin <= 2'b01;
    repeat (6) @(posedge sys_clk);
    rd16(tcc_pkg::ADDR_CNT_HI, v);
    rd(tcc_pkg::ADDR_STATUS, d);
    rd16(tcc_pkg::ADDR_CAP1_HI, w);
    chk({d[7], w}, {1'b1, v});
    wr(tcc_pkg::ADDR_CTRL_TWO, 8'h10);
    capture_pin <= 2'b00;
    repeat (6) @(posedge sys_clk);
    capture_pin <= 2'b11;
    repeat (6) @(posedge sys_clk);
    rd(tcc_pkg::ADDR_STATUS, d);
    chk({d[7], d[4]}, 2'b01);
    rd(tcc_pkg::ADDR_CAP2_LO, d);
    wr(tcc_pkg::ADDR_CTRL_TWO, 8'h00);
    halt_mode <= 1'b0;
  endtask
  task automatic t_compare();
    wr(tcc_pkg::ADDR_CTRL_ONE, 8'h45);
    wr(tcc_pkg::ADDR_CTRL_TWO, 8'hc0);
    rd(tcc_pkg::ADDR_CTRL_TWO, d);
    chk(d, 8'hc0);
    wr(tcc_pkg::ADDR_CMP1_HI, 8'h00);
    wr(tcc_pkg::ADDR_CMP1_LO, 8'h10);
    wr(tcc_pkg::ADDR_CMP2_HI, 8'h00);
    wr(tcc_pkg::ADDR_CMP2_LO, 8'h20);
    wr(tcc_pkg::ADDR_CMP2_HI, 8'h00);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h00);
    repeat (80) @(posedge sys_clk);
    chk(compare_pin_r, 2'b01);
    chk(timer_irq_r, 1'b1);
    rd(tcc_pkg::ADDR_CMP1_LO, d);
    rd(tcc_pkg::ADDR_STATUS, d);
    chk({d[6], d[3]}, 2'b10);
    wr(tcc_pkg::ADDR_CMP2_LO, 8'h40);
    repeat (70) @(posedge sys_clk);
    chk(compare_pin_r, 2'b11);
    rd(tcc_pkg::ADDR_STATUS, d);
    rd(tcc_pkg::ADDR_CMP1_LO, d);
    wr(tcc_pkg::ADDR_CMP2_LO, 8'h40);
    rd(tcc_pkg::ADDR_STATUS, d);
    chk({d[6], d[3], timer_irq_r}, 3'b000);
  endtask
  // Mid-run reset from halt: pins drop at once and counting restarts from the reload value.
  task automatic t_rewake();
    halt_mode <= 1'b1;
    rst_n     <= 1'b0;
    @(posedge sys_clk);
    chk(compare_pin_r, 16'h0000);
    repeat (4) @(posedge sys_clk);
    chk({compare_pin_r, compare_pin_oe_r, timer_irq_r}, 16'h0000);
    rst_n     <= 1'b1;
    halt_mode <= 1'b0;
    rd16(tcc_pkg::ADDR_CNT_HI, v);
    chk_near(v - tcc_pkg::COUNT_RELOAD, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic results();
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence after a five-cycle reset.
  initial begin
    rst_n       = 1'b0;
    reg_addr    = 5'h00;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    irq_mask    = 1'b1;
    halt_mode   = 1'b0;
    ext_run     = 1'b0;
    capture_pin = 2'b00;
    mismatches  = 0;
    check_count = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_overflow();
    t_readseq();
    t_clock();
    t_capture();
    t_compare();
    t_rewake();
    results();
  end

  // Watchdog well beyond the roughly 1400 cycles the scenarios need.
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    results();
  end
endmodule // tcc_timer_test
